// ===== rtl/fpe_regs.vh
`ifndef FPE_REGS_VH
`define FPE_REGS_VH

// ----------------------------------------
// register offsets on the apb side
// ----------------------------------------
`define FPE_CTRL_OFS       12'h000
`define FPE_ADDR_OFS       12'h004
`define FPE_WDATA_OFS      12'h008
`define FPE_STAT_OFS       12'h00C
`define FPE_RDATA_OFS      12'h010

// ----------------------------------------
// command codes written to ctrl[3:0]
// ----------------------------------------
`define FPE_CMD_READ       4'h0
`define FPE_CMD_PROG       4'h1
`define FPE_CMD_BERASE     4'h2
`define FPE_CMD_CERASE     4'h3
`define FPE_CMD_ADDBLK     4'h4
`define FPE_CMD_SUSP       4'h5
`define FPE_CMD_RESUME     4'h6
`define FPE_CMD_RESET      4'h7
`define FPE_CMD_POLL       4'h8
`define FPE_CMD_STATUS     4'h9
`define FPE_CMD_LAST       4'h9

// ----------------------------------------
// status register fields
// ----------------------------------------
`define FPE_ST_BUSY        0
`define FPE_ST_DONE        1
`define FPE_ST_ERR         2
`define FPE_ST_RDY         3
`define FPE_ST_FLASH_LSB   8

// ----------------------------------------
// flash command cycles and status bits
// ----------------------------------------
`define FPE_UNLK1_ADDR     20'h00555
`define FPE_UNLK2_ADDR     20'h002AA
`define FPE_D_UNLK1        8'hAA
`define FPE_D_UNLK2        8'h55
`define FPE_D_PROG         8'hA0
`define FPE_D_ERASE_SETUP  8'h80
`define FPE_D_BLOCK_ERASE  8'h30
`define FPE_D_CHIP_ERASE   8'h10
`define FPE_D_SUSPEND      8'hB0
`define FPE_D_RESUME       8'h30
`define FPE_D_READ_RESET   8'hF0
`define FPE_DQ_ERR         5
`define FPE_DQ_TOGGLE      6
`define FPE_STATUS_MASK    8'hEC

// ----------------------------------------
// timing, in ns and in pclk cycles
// ----------------------------------------
`define FPE_PCLK_NS        10
`define FPE_T_WP_NS        50
`define FPE_T_ACC_NS       100
`define FPE_T_REC_NS       30
`define FPE_WP_CYC         ((`FPE_T_WP_NS + `FPE_PCLK_NS - 1) / `FPE_PCLK_NS)
`define FPE_ACC_CYC        ((`FPE_T_ACC_NS + `FPE_PCLK_NS - 1) / `FPE_PCLK_NS)
`define FPE_REC_CYC        ((`FPE_T_REC_NS + `FPE_PCLK_NS - 1) / `FPE_PCLK_NS)
`define FPE_SYNC_CYC       2

`endif

// ===== rtl/fpe_sync2.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// two-flop synchroniser for pin inputs
// ----------------------------------------
module fpe_sync2 #(
	parameter         W       = 8,
	parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	// first stage is read only by the second; reset to the idle level
	// so no false edge follows reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule

`default_nettype wire

// ===== rtl/fpe_bus_cycle.v
`timescale 1ns/1ps
`default_nettype none
`include "fpe_regs.vh"

// ----------------------------------------
// one asynchronous flash bus cycle
// ----------------------------------------
module fpe_bus_cycle #(
	parameter WP_CYC  = `FPE_WP_CYC,
	parameter RD_CYC  = `FPE_ACC_CYC + `FPE_SYNC_CYC + 1,
	parameter REC_CYC = `FPE_REC_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        req,
	input  wire        req_write,
	input  wire [19:0] req_addr,
	input  wire [7:0]  req_wdata,
	input  wire [7:0]  dq_sync,
	output wire        idle,
	output reg         done_reg,
	output reg  [7:0]  rdata_reg,
	output reg  [19:0] flash_addr,
	output reg  [7:0]  flash_dq_out,
	output reg         flash_dq_oe,
	output reg         flash_select_n,
	output reg         flash_oe_n,
	output reg         flash_we_n
);

	localparam S_IDLE = 4'b0001;
	localparam S_SET  = 4'b0010;
	localparam S_STB  = 4'b0100;
	localparam S_REC  = 4'b1000;

	reg [3:0] state_reg;
	reg [5:0] cnt_reg;
	reg       wr_reg;

	assign idle = state_reg[0];

	// select and output enable both rise between reads, so every
	// read is a fresh strobe edge that steps the toggle bits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= S_IDLE;
			cnt_reg        <= 6'h00;
			wr_reg         <= 1'b0;
			done_reg       <= 1'b0;
			rdata_reg      <= 8'h00;
			flash_addr     <= 20'h00000;
			flash_dq_out   <= 8'h00;
			flash_dq_oe    <= 1'b0;
			flash_select_n <= 1'b1;
			flash_oe_n     <= 1'b1;
			flash_we_n     <= 1'b1;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				if (req) begin
					wr_reg         <= req_write;
					flash_addr     <= req_addr;
					flash_dq_out   <= req_wdata;
					flash_dq_oe    <= req_write;
					flash_select_n <= 1'b0;
					state_reg      <= S_SET;
				end
			end
			S_SET: begin
				flash_we_n <= ~wr_reg;
				flash_oe_n <= wr_reg;
				cnt_reg    <= wr_reg ? WP_CYC[5:0] : RD_CYC[5:0];
				state_reg  <= S_STB;
			end
			S_STB: begin
				if (cnt_reg == 6'h01) begin
					// sample late: dq_sync lags the pins by two flops
					if (!wr_reg)
						rdata_reg <= dq_sync;
					flash_we_n     <= 1'b1;
					flash_oe_n     <= 1'b1;
					flash_select_n <= 1'b1;
					cnt_reg        <= REC_CYC[5:0];
					state_reg      <= S_REC;
				end else begin
					cnt_reg <= cnt_reg - 6'h01;
				end
			end
			S_REC: begin
				// data held through recovery for write hold time
				if (cnt_reg <= 6'h01) begin
					flash_dq_oe <= 1'b0;
					done_reg    <= 1'b1;
					state_reg   <= S_IDLE;
				end else begin
					cnt_reg <= cnt_reg - 6'h01;
				end
			end
			default: begin
				state_reg <= S_IDLE;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== rtl/fpe_ctrl.v
// How it works
// - host polls at the programmed address or inside an erasing block.
// - toggling stops on completion; host sees two equal bit 6 reads.
// - queue blocks while bit 3 is 0; afterwards only suspend. The controller sends ADDBLK and any other command without checking bit 3.
// - host masks data bits 0, 1 and 4 when reading status.
// - host writes F0h to return to array read and clear error.
// - host suspends with one B0h write then reads until toggling stops.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_regs.vh"

module fpe_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire [19:0] flash_addr,
	input  wire [7:0]  flash_dq_in,
	output wire [7:0]  flash_dq_out,
	output wire        flash_dq_oe,
	output wire        flash_select_n,
	output wire        flash_oe_n,
	output wire        flash_we_n,
	input  wire        ready_busy_n
);

	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	localparam S_IDLE  = 5'b00001;
	localparam S_WRITE = 5'b00010;
	localparam S_POLL  = 5'b00100;
	localparam S_FINAL = 5'b01000;
	localparam S_READ  = 5'b10000;

	reg  [4:0]  state_reg;
	reg  [3:0]  cmd_reg;
	reg  [2:0]  step_reg;
	reg         wait_reg;
	reg  [19:0] addr_reg;
	reg  [7:0]  wdata_reg;
	reg  [7:0]  rdata_reg;
	reg  [7:0]  flash_stat_reg;
	reg         done_reg;
	reg         err_reg;
	reg         have_prev_reg;
	reg         prev_tog_reg;
	reg         err_chk_reg;
	reg         bus_req;
	reg         bus_write;
	reg  [27:0] seq_word;
	wire        bus_idle;
	wire        bus_done;
	wire [7:0]  bus_rdata;
	wire [7:0]  dq_sync;
	wire        rdy_sync;
	wire        busy;
	wire        wr_access;
	wire        mapped;
	wire        start_ok;
	wire        tog_now;
	wire        err_now;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	fpe_sync2 #(
		.W       (9),
		.RST_VAL (9'h1FF)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({ready_busy_n, flash_dq_in}),
		.sync_out ({rdy_sync, dq_sync})
	);

	// ----------------------------------------
	// flash bus cycle engine
	// ----------------------------------------
	fpe_bus_cycle u_bus (
		.pclk           (pclk),
		.presetn        (presetn),
		.req            (bus_req),
		.req_write      (bus_write),
		.req_addr       (seq_word[27:8]),
		.req_wdata      (seq_word[7:0]),
		.dq_sync        (dq_sync),
		.idle           (bus_idle),
		.done_reg       (bus_done),
		.rdata_reg      (bus_rdata),
		.flash_addr     (flash_addr),
		.flash_dq_out   (flash_dq_out),
		.flash_dq_oe    (flash_dq_oe),
		.flash_select_n (flash_select_n),
		.flash_oe_n     (flash_oe_n),
		.flash_we_n     (flash_we_n)
	);

	// ----------------------------------------
	// command cycle tables
	// ----------------------------------------
	// number of write cycles each command sends
	function [2:0] nwrites;
		input [3:0] cmd;
		begin
			case (cmd)
			`FPE_CMD_PROG:   nwrites = 3'd4;
			`FPE_CMD_BERASE: nwrites = 3'd6;
			`FPE_CMD_CERASE: nwrites = 3'd6;
			`FPE_CMD_ADDBLK: nwrites = 3'd1;
			`FPE_CMD_SUSP:   nwrites = 3'd1;
			`FPE_CMD_RESUME: nwrites = 3'd1;
			`FPE_CMD_RESET:  nwrites = 3'd1;
			default:         nwrites = 3'd0;
			endcase
		end
	endfunction

	// address and data of each write cycle
	always @* begin
		seq_word = {addr_reg, 8'h00}; // reads poll the target address
		if (state_reg == S_WRITE) begin
			case (cmd_reg)
			`FPE_CMD_PROG: begin
				case (step_reg)
				3'd0:    seq_word = {`FPE_UNLK1_ADDR, `FPE_D_UNLK1};
				3'd1:    seq_word = {`FPE_UNLK2_ADDR, `FPE_D_UNLK2};
				3'd2:    seq_word = {`FPE_UNLK1_ADDR, `FPE_D_PROG};
				default: seq_word = {addr_reg, wdata_reg};
				endcase
			end
			`FPE_CMD_BERASE, `FPE_CMD_CERASE: begin
				case (step_reg)
				3'd0, 3'd3: seq_word = {`FPE_UNLK1_ADDR, `FPE_D_UNLK1};
				3'd1, 3'd4: seq_word = {`FPE_UNLK2_ADDR, `FPE_D_UNLK2};
				3'd2:       seq_word = {`FPE_UNLK1_ADDR, `FPE_D_ERASE_SETUP};
				default: begin
					if (cmd_reg == `FPE_CMD_CERASE)
						seq_word = {`FPE_UNLK1_ADDR, `FPE_D_CHIP_ERASE};
					else
						seq_word = {addr_reg, `FPE_D_BLOCK_ERASE};
				end
				endcase
			end
			`FPE_CMD_ADDBLK: seq_word = {addr_reg, `FPE_D_BLOCK_ERASE};
			`FPE_CMD_SUSP:   seq_word = {addr_reg, `FPE_D_SUSPEND};
			`FPE_CMD_RESUME: seq_word = {addr_reg, `FPE_D_RESUME};
			default:         seq_word = {addr_reg, `FPE_D_READ_RESET};
			endcase
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign busy      = ~state_reg[0];
	assign pready    = 1'b1;
	assign wr_access = psel & penable & pwrite;
	assign mapped    = (paddr == `FPE_CTRL_OFS) | (paddr == `FPE_ADDR_OFS) |
	                   (paddr == `FPE_WDATA_OFS) | (paddr == `FPE_STAT_OFS) |
	                   (paddr == `FPE_RDATA_OFS);
	assign pslverr   = psel & penable & ~mapped;
	// a new command while busy is dropped; software watches busy
	assign start_ok  = wr_access & (paddr == `FPE_CTRL_OFS) & ~busy &
	                   (pwdata[3:0] <= `FPE_CMD_LAST);

	// read data latched in the setup phase, so it comes from a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
			`FPE_CTRL_OFS:  prdata <= {28'h0000000, cmd_reg};
			`FPE_ADDR_OFS:  prdata <= {12'h000, addr_reg};
			`FPE_WDATA_OFS: prdata <= {24'h000000, wdata_reg};
			`FPE_STAT_OFS:  prdata <= {16'h0000, flash_stat_reg, 4'h0, rdy_sync, err_reg, done_reg, busy};
			`FPE_RDATA_OFS: prdata <= {24'h000000, rdata_reg};
			default:        prdata <= 32'h00000000;
			endcase
		end
	end

	// address and data only change while idle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg  <= 20'h00000;
			wdata_reg <= 8'h00;
		end else if (wr_access & ~busy) begin
			if (paddr == `FPE_ADDR_OFS)
				addr_reg <= pwdata[19:0];
			if (paddr == `FPE_WDATA_OFS)
				wdata_reg <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// bus requests
	// ----------------------------------------
	always @* begin
		bus_req   = 1'b0;
		bus_write = 1'b0;
		if (bus_idle & ~wait_reg) begin
			bus_req   = (state_reg != S_IDLE);
			bus_write = (state_reg == S_WRITE);
		end
	end

	assign tog_now = bus_rdata[`FPE_DQ_TOGGLE];
	assign err_now = bus_rdata[`FPE_DQ_ERR];

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= S_IDLE;
			cmd_reg        <= 4'h0;
			step_reg       <= 3'd0;
			wait_reg       <= 1'b0;
			rdata_reg      <= 8'h00;
			flash_stat_reg <= 8'h00;
			done_reg       <= 1'b0;
			err_reg        <= 1'b0;
			have_prev_reg  <= 1'b0;
			prev_tog_reg   <= 1'b0;
			err_chk_reg    <= 1'b0;
		end else begin
			if (bus_req)
				wait_reg <= 1'b1;
			if (bus_done)
				wait_reg <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				if (start_ok) begin
					cmd_reg       <= pwdata[3:0];
					step_reg      <= 3'd0;
					done_reg      <= 1'b0;
					have_prev_reg <= 1'b0;
					err_chk_reg   <= 1'b0;
					if (nwrites(pwdata[3:0]) != 3'd0)
						state_reg <= S_WRITE;
					else if (pwdata[3:0] == `FPE_CMD_POLL)
						state_reg <= S_POLL;
					else
						state_reg <= S_READ;
				end
			end
			S_WRITE: begin
				if (bus_done) begin
					if (step_reg == nwrites(cmd_reg) - 3'd1) begin
						// polling only after the last command write
						case (cmd_reg)
						`FPE_CMD_PROG, `FPE_CMD_CERASE,
						`FPE_CMD_SUSP, `FPE_CMD_RESUME: begin
							state_reg <= S_POLL;
						end
						`FPE_CMD_RESET: begin
							err_reg   <= 1'b0;
							done_reg  <= 1'b1;
							state_reg <= S_IDLE;
						end
						default: begin
							// block erase stays open for more blocks
							done_reg  <= 1'b1;
							state_reg <= S_IDLE;
						end
						endcase
					end else begin
						step_reg <= step_reg + 3'd1;
					end
				end
			end
			S_POLL: begin
				if (bus_done) begin
					flash_stat_reg <= bus_rdata & `FPE_STATUS_MASK;
					have_prev_reg  <= 1'b1;
					prev_tog_reg   <= tog_now;
					if (have_prev_reg & (tog_now == prev_tog_reg)) begin
						state_reg <= S_FINAL;
					end else if (have_prev_reg & err_chk_reg) begin
						// still toggling after the error flag: failed
						err_reg   <= 1'b1;
						done_reg  <= 1'b1;
						state_reg <= S_IDLE;
					end else begin
						err_chk_reg <= err_now;
					end
				end
			end
			S_FINAL: begin
				// toggling has stopped, so this read is array data, or suspend status after a suspend inside an erasing block
				if (bus_done) begin
					rdata_reg <= bus_rdata;
					done_reg  <= 1'b1;
					state_reg <= S_IDLE;
				end
			end
			S_READ: begin
				if (bus_done) begin
					if (cmd_reg == `FPE_CMD_STATUS)
						flash_stat_reg <= bus_rdata & `FPE_STATUS_MASK;
					rdata_reg <= bus_rdata;
					done_reg  <= 1'b1;
					state_reg <= S_IDLE;
				end
			end
			default: begin
				state_reg <= S_IDLE;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== verification/fpe_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------
// flash pin checker
// --------------------
module fpe_ctrl_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [19:0] flash_addr,
	input wire logic [7:0]  flash_dq_in,
	input wire logic [7:0]  flash_dq_out,
	input wire logic        flash_dq_oe,
	input wire logic        flash_select_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_we_n,
	input wire logic        ready_busy_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// write cycles carry driven data to a selected die
	a_write_drives_bus: assert property (!flash_we_n |-> flash_dq_oe && !flash_select_n)
		else $error("write strobe without driven data");
	a_read_undriven: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
		else $error("bus contention during read");
	a_write_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
		else $error("write pulse not five cycles");
	a_read_width: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8] ##1 !flash_oe_n [*5] ##1 flash_oe_n)
		else $error("read strobe not thirteen cycles");
	// every read must end with a fresh select edge, else the toggle stalls
	a_fresh_select: assert property ($rose(flash_oe_n) |-> $rose(flash_select_n))
		else $error("select kept low across reads");
	a_recovery_gap: assert property ($rose(flash_select_n) |-> flash_select_n [*3])
		else $error("recovery shorter than three cycles");
	a_addr_held: assert property (!flash_select_n && !$past(flash_select_n) |-> $stable(flash_addr))
		else $error("address moved inside a cycle");
	a_dq_hold: assert property ($rose(flash_we_n) |-> flash_dq_oe [*2])
		else $error("data released with the strobe");

	c_suspend: cover property ($rose(flash_we_n) && flash_dq_out == 8'hB0);
	c_reset: cover property ($rose(flash_we_n) && flash_dq_out == 8'hF0);
	c_unmapped: cover property (pslverr);
endmodule

bind fpe_ctrl fpe_ctrl_properties i_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.flash_addr(flash_addr), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
	.flash_select_n(flash_select_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .ready_busy_n(ready_busy_n));

`default_nettype wire

// ===== verification/fpe_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------
// behavioural flash die
// --------------------
module fpe_flash_model #(
	parameter int TMR_NS  = 50000,
	parameter int PROT_NS = 100000
) (
	input  wire logic [19:0] flash_addr,
	input  wire logic [7:0]  dq_bus,
	input  wire logic        flash_oe_n,
	input  wire logic        flash_we_n,
	output logic      [7:0]  dev_dq,
	output logic             ready_busy_n
);
	logic [7:0]  mem [0:20'hFFFFF];
	logic [15:0] eblk = 16'h0000;
	logic [15:0] prot = 16'h0000; // blocks that refuse erase
	logic [7:0]  pdata;
	logic [19:0] paddr;
	logic        prog = 0, ers = 0, susp = 0, err = 0, t6 = 0, t2 = 0;
	realtime     tend = 0;
	int          busy_len = 2, left, step = 0;

	// blank array, bus pattern not zero
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		dev_dq = 8'h5A;
	end

	assign ready_busy_n = !(prog || (ers && !susp));

	// commands land on the write strobe's rising edge
	always @(posedge flash_we_n) begin
		if (dq_bus == 8'hF0) begin
			{prog, ers, susp, err} = 4'h0;
			step = 0;
		end else if (ers && !susp) begin
			if (dq_bus == 8'hB0 && $realtime >= tend) susp = 1;
			else if (dq_bus == 8'h30 && $realtime < tend) begin
				eblk[flash_addr[19:16]] = 1;
				tend = $realtime + TMR_NS;
			end
		end else if (!prog) begin
			if (susp && step == 0 && dq_bus == 8'h30) susp = 0;
			else case (step)
				0: step = (dq_bus == 8'hAA) ? 1 : 0;
				1, 5: step = (dq_bus == 8'h55) ? step + 1 : 0;
				2: step = (dq_bus == 8'hA0) ? 3 : (dq_bus == 8'h80) ? 4 : 0;
				3: begin
					pdata = dq_bus;
					paddr = flash_addr;
					err = |(dq_bus & ~mem[flash_addr]);
					prog = 1;
					left = busy_len;
					step = 0;
				end
				4: step = (dq_bus == 8'hAA) ? 5 : 0;
				6: begin
					ers = 1;
					left = busy_len;
					step = 0;
					eblk = (dq_bus == 8'h10) ? 16'hFFFF : 16'h0001 << flash_addr[19:16];
					tend = $realtime + ((dq_bus == 8'h10) ? 0 : TMR_NS);
				end
				default: step = 0;
			endcase
		end
	end

	// status or array byte chosen at each read strobe
	always @(negedge flash_oe_n) begin
		logic hit, dq3;
		hit = eblk[flash_addr[19:16]];
		dq3 = $realtime >= tend;
		t6 = ~t6;
		if ((ers || susp) && hit) t2 = ~t2;
		if (prog) begin
			dev_dq = {~pdata[7], t6, err, 1'b0, dq3, 1'b1, 2'b00};
			if (!err) left = left - 1;
			if (!err && left <= 0) begin
				mem[paddr] = pdata;
				prog = 0;
			end
		end else if (ers && !susp) begin
			dev_dq = {1'b0, t6, 2'b00, dq3, hit ? t2 : 1'b1, 2'b00};
			if (dq3) left = left - 1;
			// all blocks protected: status stays a while, array untouched
			if (left <= 0 && ((eblk & ~prot) != 16'h0000 || $realtime >= tend + PROT_NS)) begin
				for (int a = 0; a < 2**20; a++) if (eblk[a >> 16] && !prot[a >> 16]) mem[a] = 8'hFF;
				ers = 0;
				eblk = 16'h0000;
			end
		end else if (susp && hit) dev_dq = {2'b11, 2'b00, dq3, t2, 2'b00};
		else dev_dq = mem[flash_addr];
	end

	// released bus shows the inverse, never a stale byte
	always @(posedge flash_oe_n) dev_dq = ~dev_dq;
endmodule

`default_nettype wire

// ===== verification/flash_prog_erase_status_bits_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpe_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module flash_prog_erase_status_bits_tb;
	logic        pclk, presetn, psel, penable, pwrite, slv, pready, pslverr, dq_oe, sel_n, oe_n, we_n, rb_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, st;
	logic [19:0] faddr, a;
	logic [7:0]  dq_out, dev_dq, rd, d;
	logic        b;
	logic [31:0] seed = 32'h0000_6ADB;
	logic [7:0]  ref_m [logic [19:0]];
	int          error_cnt = 0, tests_run = 0;
	wire  [7:0]  dq = dq_oe ? dq_out : dev_dq;

	fpe_ctrl i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(faddr), .flash_dq_in(dq),
		.flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_select_n(sel_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.ready_busy_n(rb_n));
	fpe_flash_model i_dev (.flash_addr(faddr), .dq_bus(dq), .flash_oe_n(oe_n), .flash_we_n(we_n), .dev_dq(dev_dq),
		.ready_busy_n(rb_n));

	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end

	// --------------------
	// helpers
	// --------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] refv(input logic [19:0] x);
		return ref_m.exists(x) ? ref_m[x] : 8'hFF;
	endfunction

	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one command, wait for done, then fetch the data byte
	task automatic cmd(input logic [3:0] c, input logic [19:0] ad, input logic [7:0] wd);
		int n;
		apb(1'b1, `FPE_ADDR_OFS, {12'h000, ad});
		apb(1'b1, `FPE_WDATA_OFS, {24'h000000, wd});
		apb(1'b1, `FPE_CTRL_OFS, {28'h0000000, c});
		n = 0;
		do begin
			apb(1'b0, `FPE_STAT_OFS, 32'h0);
			n++;
		end while (r[1] !== 1'b1 && n < 20000);
		st = r;
		`CHK(st[1], 1'b1)
		apb(1'b0, `FPE_RDATA_OFS, 32'h0);
		rd = r[7:0];
	endtask

	// program, expecting failure when a cleared bit would be set
	task automatic prog(input logic [19:0] ad, input logic [7:0] wd);
		logic e;
		e = |(wd & ~refv(ad));
		cmd(`FPE_CMD_PROG, ad, wd);
		`CHK(st[2], e)
		if (e) begin
			cmd(`FPE_CMD_RESET, ad, 8'h00);
			`CHK(st[2], 1'b0)
		end else begin
			`CHK(rd, wd)
			ref_m[ad] = wd;
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		#900000;
		error_cnt++;
		end_of_test();
	end

	// --------------------
	// scenarios
	// --------------------
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// reset value, read-only status, unmapped slot, narrow address
		apb(1'b1, `FPE_STAT_OFS, 32'hFFFF_FFFF);
		apb(1'b0, `FPE_STAT_OFS, 32'h0);
		`CHK(r, 32'h0000_0008)
		apb(1'b0, 12'h014, 32'h0);
		`CHK(slv, 1'b1)
		apb(1'b1, `FPE_ADDR_OFS, 32'hFFFF_FFFF);
		apb(1'b0, `FPE_ADDR_OFS, 32'h0);
		`CHK(r, 32'h000F_FFFF)
		// random bytes, prompt and slow die, one reprogram over cleared bits
		for (int i = 0; i < 10; i++) begin
			i_dev.busy_len = (i % 2) ? 6 : 1;
			r = rnd();
			if (i != 4) a = {4'h1, r[15:0]};
			d = (i == 4) ? ~d : r[23:16];
			prog(a, d);
		end
		// block erase with a queued block, then suspend and resume
		prog(20'h3_0010, 8'h5A);
		prog(20'h5_0004, 8'hC3);
		i_dev.busy_len = 6;
		cmd(`FPE_CMD_BERASE, 20'h2_0000, 8'h00);
		cmd(`FPE_CMD_STATUS, 20'h2_0000, 8'h00);
		`CHK(st[15:8] & 8'hA8, 8'h00)
		b = st[14];
		cmd(`FPE_CMD_ADDBLK, 20'h3_0000, 8'h00);
		cmd(`FPE_CMD_STATUS, 20'h5_0004, 8'h00);
		`CHK(st[15:8] & 8'hA4, 8'h04)
		`CHK(st[14], ~b)
		for (int n = 0; n < 400 && st[11] !== 1'b1; n++) cmd(`FPE_CMD_STATUS, 20'h2_0000, 8'h00);
		`CHK(st[11], 1'b1)
		cmd(`FPE_CMD_SUSP, 20'h3_0000, 8'h00);
		cmd(`FPE_CMD_STATUS, 20'h3_0010, 8'h00);
		`CHK(st[15:8] & 8'hE8, 8'hC8)
		b = st[10];
		cmd(`FPE_CMD_STATUS, 20'h3_0010, 8'h00);
		`CHK(st[10], ~b)
		cmd(`FPE_CMD_STATUS, 20'h5_0004, 8'h00);
		`CHK(st[15:8], 8'hC3 & 8'hEC)
		prog(20'h5_0008, 8'h81);
		cmd(`FPE_CMD_RESUME, 20'h2_0000, 8'h00);
		`CHK(rd, 8'hFF)
		cmd(`FPE_CMD_READ, 20'h3_0010, 8'h00);
		`CHK(rd, 8'hFF)
		cmd(`FPE_CMD_READ, 20'h5_0004, 8'h00);
		`CHK(rd, 8'hC3)
		// whole-chip erase
		i_dev.busy_len = 3;
		cmd(`FPE_CMD_CERASE, 20'h0_0000, 8'h00);
		`CHK(rd, 8'hFF)
		cmd(`FPE_CMD_READ, a, 8'h00);
		`CHK(rd, 8'hFF)
		`CHK(st[2], 1'b0)
		// erase of a protected block only: status for a while, data kept
		i_dev.prot = 16'h0040;
		prog(20'h6_0000, 8'h00);
		cmd(`FPE_CMD_BERASE, 20'h6_0000, 8'h00);
		cmd(`FPE_CMD_STATUS, 20'h6_0000, 8'h00);
		`CHK(st[15], 1'b0)
		b = st[14];
		cmd(`FPE_CMD_STATUS, 20'h6_0000, 8'h00);
		`CHK(st[14], ~b)
		cmd(`FPE_CMD_POLL, 20'h6_0000, 8'h00);
		`CHK(rd, 8'h00)
		end_of_test();
	end
endmodule

`default_nettype wire
